// ===== rtl/dsp_exec_consts.vh
// constants for the special-function and control instruction execution block
`ifndef DSP_EXEC_CONSTS_VH
`define DSP_EXEC_CONSTS_VH
// register byte offsets
`define OFF_INSTR      8'h00
`define OFF_SRC        8'h04
`define OFF_EXEC       8'h08
`define OFF_ACC0_LO    8'h0c
`define OFF_ACC0_HI    8'h10
`define OFF_ACC1_LO    8'h14
`define OFF_ACC1_HI    8'h18
`define OFF_COUNTERS   8'h1c
`define OFF_SNAPSHOT   8'h20
`define OFF_PC         8'h24
`define OFF_STATUS     8'h28
`define OFF_FLAGS      8'h2c
`define OFF_RETREGS    8'h30
`define OFF_CONFIG     8'h34
// instruction word fields
`define F_CLASS_HI     15
`define F_CLASS_LO     14
`define F_COND_FLAG    13
`define F_EVENT_FLAG   12
`define F_DEST_BIT     11
`define F_SRC_BIT      10
`define F_OP_HI        9
`define F_OP_LO        5
`define F_CC_HI        4
`define F_CC_LO        0
// instruction classes
`define CLS_SPECIAL    2'h0
`define CLS_CONTROL    2'h1
// special function opcodes
`define SF_SHR1        5'h00
`define SF_SHR4        5'h01
`define SF_SHR8        5'h02
`define SF_SHR16       5'h03
`define SF_MOVE        5'h04
`define SF_NEG         5'h05
`define SF_INV         5'h06
`define SF_RND         5'h07
`define SF_INCH        5'h08
`define SF_INC         5'h09
`define SF_LDY         5'h0a
`define SF_LDP         5'h0b
`define SF_SHL1        5'h0c
`define SF_SHL4        5'h0d
`define SF_SHL8        5'h0e
`define SF_SHL16       5'h0f
// control opcodes
`define CT_GOTO_ABS    5'h00
`define CT_GOTO_PTR    5'h01
`define CT_CALL_ABS    5'h02
`define CT_CALL_PTR    5'h03
`define CT_ICALL       5'h04
`define CT_RETURN      5'h05
`define CT_IRETURN     5'h06
// condition codes
`define CC_MI          5'h00
`define CC_PL          5'h01
`define CC_EQ          5'h02
`define CC_NE          5'h03
`define CC_GT          5'h04
`define CC_LE          5'h05
`define CC_LVS         5'h06
`define CC_LVC         5'h07
`define CC_MVS         5'h08
`define CC_MVC         5'h09
`define CC_COUNTER_ZERO_NONNEG_TEST        5'h0a
`define CC_C0LT        5'h0b
`define CC_C1GE        5'h0c
`define CC_COUNTER_ONE_NEGATIVE_TEST        5'h0d
`define CC_HEADS       5'h0e
`define CC_TAILS       5'h0f
`define CC_TRUE        5'h10
`define CC_FALSE       5'h11
`define CC_ALLT        5'h12
`define CC_ALLF        5'h13
`define CC_SOMET       5'h14
`define CC_SOMEF       5'h15
`define CC_ODDP        5'h16
`define CC_EVENP       5'h17
`define CC_MINUS_ONE_FLAG        5'h18
`define CC_NOT_MINUS_ONE_FLAG       5'h19
`define CC_NPINT       5'h1a
`define CC_NJINT       5'h1b
`define CC_LOCK        5'h1c
// cycle counts
`define CYC_SPECIAL    3'h1
`define CYC_CTRL_UNC   3'h2
`define CYC_CTRL_COND  3'h3
`define CYC_ICALL      3'h3
// memory layout
`define PAGE_BITS      12
`define EXT_BOUNDARY   16'h8000
// reset values
`define RST_WAIT       4'h0
`define RST_PRNG       10'h001
`endif

// ===== rtl/dsp_exec.v
// special-function, control-flow and condition evaluation core with wishbone registers
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "dsp_exec_consts.vh"
module dsp_exec #(
    parameter ACC_W = 36,
    parameter PC_W  = 16
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // operand and flag inputs
    input  wire [31:0] mult_input_i,
    input  wire [31:0] product_i,
    input  wire [3:0]  result_flags_i,
    input  wire        result_flags_we_i,
    input  wire [1:0]  bmu_flags_i,
    input  wire [3:0]  bio_compare_i,
    input  wire        pll_lock_i,
    input  wire        npint_i,
    input  wire        njint_i,
    input  wire        cache_active_i,
    // status outputs
    output reg         busy_o,
    output reg         branch_taken_o,
    output reg  [15:0] pc_o
);

    // state machine
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    // architectural state
    reg [ACC_W-1:0] acc0_reg;
    reg [ACC_W-1:0] acc1_reg;
    reg [15:0]      loop_counter_zero_reg;
    reg [15:0]      loop_counter_one_reg;
    reg [15:0]      counter_snapshot_reg;
    reg [PC_W-1:0]  pc_reg;
    reg [PC_W-1:0]  subroutine_return_reg;
    reg [PC_W-1:0]  interrupt_return_reg;
    reg [PC_W-1:0]  table_pointer_reg;
    reg [9:0]       prng_reg;
    reg [3:0]       flags_reg;          // {mv, lv, zero, neg}
    reg [3:0]       wait_states_reg;
    reg [15:0]      instr_reg;
    reg [2:0]       cycles_reg;
    reg             cache_err_reg;
    reg             last_cond_reg;
    reg             state_reg;
    reg [2:0]       count_reg;

    // decoded instruction fields
    wire [1:0]  cls        = instr_reg[`F_CLASS_HI:`F_CLASS_LO];
    wire        is_cond    = instr_reg[`F_COND_FLAG];
    wire        is_event   = instr_reg[`F_EVENT_FLAG];
    wire        dest_sel   = instr_reg[`F_DEST_BIT];
    wire        src_sel    = instr_reg[`F_SRC_BIT];
    wire [4:0]  opcode     = instr_reg[`F_OP_HI:`F_OP_LO];
    wire [4:0]  condition_code = instr_reg[`F_CC_HI:`F_CC_LO];
    wire [ACC_W-1:0] source_accumulator = src_sel ? acc1_reg : acc0_reg;

    // sign-extend a 32-bit value into the guard bits
    function [35:0] sext32;
        input [31:0] v;
        begin
            sext32 = {{4{v[31]}}, v};
        end
    endfunction

    // guard bits refilled from bit 31 after a left shift of the low word
    function [35:0] shl_low;
        input [35:0] a;
        input [4:0]  n;
        reg   [31:0] t;
        begin
            t = a[31:0] << n;
            shl_low = sext32(t);
        end
    endfunction

    // address lies in external program space
    function is_ext;
        input [15:0] addr;
        begin
            is_ext = (addr >= `EXT_BOUNDARY);
        end
    endfunction

    // special function datapath
    reg [ACC_W-1:0] sf_result;
    always @* begin
        case (opcode)
            `SF_SHR1:  sf_result = $signed(source_accumulator) >>> 1;
            `SF_SHR4:  sf_result = $signed(source_accumulator) >>> 4;
            `SF_SHR8:  sf_result = $signed(source_accumulator) >>> 8;
            `SF_SHR16: sf_result = $signed(source_accumulator) >>> 16;
            `SF_MOVE:  sf_result = source_accumulator;
            `SF_NEG:   sf_result = ~source_accumulator + 36'h000000001;
            `SF_INV:   sf_result = ~source_accumulator;
            // round: add half an lsb of the kept part, clear the low 16
            `SF_RND:   sf_result = (source_accumulator + 36'h000008000)
                                   & 36'hfffff0000;
            `SF_INCH:  sf_result = {source_accumulator[35:16] + 20'h00001,
                                   16'h0000};
            `SF_INC:   sf_result = source_accumulator + 36'h000000001;
            `SF_LDY:   sf_result = sext32(mult_input_i);
            `SF_LDP:   sf_result = sext32(product_i);
            `SF_SHL1:  sf_result = shl_low(source_accumulator, 5'd1);
            `SF_SHL4:  sf_result = shl_low(source_accumulator, 5'd4);
            `SF_SHL8:  sf_result = shl_low(source_accumulator, 5'd8);
            `SF_SHL16: sf_result = shl_low(source_accumulator, 5'd16);
            default:   sf_result = source_accumulator;
        endcase
    end

    // condition evaluation from stored flags, loop counters, the random bit and live unit inputs, never from live accumulators
    reg cond_true;
    always @* begin
        case (condition_code)
            `CC_MI:    cond_true = flags_reg[0];
            `CC_PL:    cond_true = ~flags_reg[0];
            `CC_EQ:    cond_true = flags_reg[1];
            `CC_NE:    cond_true = ~flags_reg[1];
            `CC_GT:    cond_true = ~flags_reg[0] & ~flags_reg[1];
            `CC_LE:    cond_true = flags_reg[0] | flags_reg[1];
            `CC_LVS:   cond_true = flags_reg[2];
            `CC_LVC:   cond_true = ~flags_reg[2];
            `CC_MVS:   cond_true = flags_reg[3];
            `CC_MVC:   cond_true = ~flags_reg[3];
            `CC_COUNTER_ZERO_NONNEG_TEST:  cond_true = ~loop_counter_zero_reg[15];
            `CC_C0LT:  cond_true = loop_counter_zero_reg[15];
            `CC_C1GE:  cond_true = ~loop_counter_one_reg[15];
            `CC_COUNTER_ONE_NEGATIVE_TEST:  cond_true = loop_counter_one_reg[15];
            `CC_HEADS: cond_true = prng_reg[0];
            `CC_TAILS: cond_true = ~prng_reg[0];
            `CC_TRUE:  cond_true = 1'b1;
            `CC_FALSE: cond_true = 1'b0;
            `CC_ALLT:  cond_true = bio_compare_i[0];
            `CC_ALLF:  cond_true = bio_compare_i[1];
            `CC_SOMET: cond_true = bio_compare_i[2];
            `CC_SOMEF: cond_true = bio_compare_i[3];
            `CC_ODDP:  cond_true = bmu_flags_i[0];
            `CC_EVENP: cond_true = ~bmu_flags_i[0];
            `CC_MINUS_ONE_FLAG:  cond_true = bmu_flags_i[1];
            `CC_NOT_MINUS_ONE_FLAG: cond_true = ~bmu_flags_i[1];
            `CC_NPINT: cond_true = npint_i;
            `CC_NJINT: cond_true = njint_i;
            `CC_LOCK:  cond_true = pll_lock_i;
            default:   cond_true = 1'b0;
        endcase
    end

    // control flow decode
    wire [PC_W-1:0] pc_plus1 = pc_reg + 16'h0001;
    wire [PC_W-1:0] pc_plus2 = pc_reg + 16'h0002;
    wire is_ctrl     = (cls == `CLS_CONTROL);
    // never-conditional forms ignore the conditional bit
    wire never_cond  = (opcode == `CT_ICALL) || (opcode == `CT_IRETURN);
    wire ctrl_cond   = is_cond && !never_cond;
    wire do_exec     = !(is_cond || is_event) || (is_ctrl && never_cond) || cond_true;
    wire [PC_W-1:0] next_seq = (is_ctrl && ctrl_cond) ? pc_plus2 : pc_plus1;
    // page bits from the pc two words on, so both last page slots land in the next page
    wire [11:0] jump_target_field = instr_reg[11:0];
    wire [PC_W-1:0] abs_target = {pc_plus2[PC_W-1:`PAGE_BITS], jump_target_field};
    reg [PC_W-1:0] ctrl_target;
    reg [2:0]      ctrl_cycles;
    always @* begin
        case (opcode)
            `CT_GOTO_PTR, `CT_CALL_PTR: ctrl_target = table_pointer_reg;
            `CT_ICALL:   ctrl_target = {PC_W{1'b0}};
            `CT_RETURN:  ctrl_target = subroutine_return_reg;
            `CT_IRETURN: ctrl_target = interrupt_return_reg;
            default:     ctrl_target = abs_target;
        endcase
        if (opcode == `CT_ICALL)
            ctrl_cycles = `CYC_ICALL;
        else if (ctrl_cond)
            ctrl_cycles = `CYC_CTRL_COND;
        else
            ctrl_cycles = `CYC_CTRL_UNC;
    end
    // wait-states: pc for all, plus the table pointer for pointer forms or the subroutine return register for return
    wire ext_used = is_ext(pc_reg) ||
                    (is_ctrl && ((opcode == `CT_GOTO_PTR || opcode == `CT_CALL_PTR)
                                 ? is_ext(table_pointer_reg)
                                 : (opcode == `CT_RETURN) ? is_ext(subroutine_return_reg)
                                 : 1'b0));
    wire [2:0] base_cycles = is_ctrl ? ctrl_cycles : `CYC_SPECIAL;
    wire [4:0] total_cycles = {2'b00, base_cycles}
                            + (ext_used ? {1'b0, wait_states_reg} : 5'h00);

    // wishbone decode
    wire bus_req = cyc_i && stb_i && !ack_o;
    wire wr = bus_req && we_i;
    wire exec_start = wr && (adr_i == `OFF_EXEC) && (state_reg == ST_IDLE);
    // a control word presented while running from cache is refused
    wire cache_refuse = exec_start && is_ctrl && cache_active_i;
    reg  [4:0] wait_count_reg;

    // execution sequencer and architectural updates
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc0_reg              <= 36'h000000000;
            acc1_reg              <= 36'h000000000;
            loop_counter_zero_reg <= 16'h0000;
            loop_counter_one_reg  <= 16'h0000;
            counter_snapshot_reg  <= 16'h0000;
            pc_reg                <= 16'h0000;
            subroutine_return_reg <= 16'h0000;
            interrupt_return_reg  <= 16'h0000;
            table_pointer_reg     <= 16'h0000;
            prng_reg              <= `RST_PRNG;
            flags_reg             <= 4'h0;
            wait_states_reg       <= `RST_WAIT;
            instr_reg             <= 16'h0000;
            cycles_reg            <= 3'h0;
            cache_err_reg         <= 1'b0;
            last_cond_reg         <= 1'b0;
            state_reg             <= ST_IDLE;
            wait_count_reg        <= 5'h00;
            busy_o                <= 1'b0;
            branch_taken_o        <= 1'b0;
            pc_o                  <= 16'h0000;
        end else begin
            branch_taken_o <= 1'b0;
            // flags from the arithmetic unit, held until the next update
            if (result_flags_we_i)
                flags_reg <= result_flags_i;
            if (wr && adr_i == `OFF_INSTR && state_reg == ST_IDLE)
                instr_reg <= dat_i[15:0];
            if (wr && adr_i == `OFF_CONFIG)
                wait_states_reg <= dat_i[3:0];
            // software preload: low word or guard bits of an accumulator
            if (wr && adr_i == `OFF_ACC0_LO) acc0_reg[31:0]  <= dat_i;
            if (wr && adr_i == `OFF_ACC0_HI) acc0_reg[35:32] <= dat_i[3:0];
            if (wr && adr_i == `OFF_ACC1_LO) acc1_reg[31:0]  <= dat_i;
            if (wr && adr_i == `OFF_ACC1_HI) acc1_reg[35:32] <= dat_i[3:0];
            if (wr && adr_i == `OFF_SRC) begin
                table_pointer_reg <= dat_i[15:0];
                pc_reg            <= dat_i[31:16];
                pc_o              <= dat_i[31:16];
            end
            if (wr && adr_i == `OFF_RETREGS) begin
                subroutine_return_reg <= dat_i[15:0];
                interrupt_return_reg  <= dat_i[31:16];
            end
            if (wr && adr_i == `OFF_COUNTERS) begin
                loop_counter_zero_reg <= dat_i[15:0];
                loop_counter_one_reg  <= dat_i[31:16];
            end
            if (wr && adr_i == `OFF_STATUS && dat_i[0])
                cache_err_reg <= 1'b0;
            if (cache_refuse)
                cache_err_reg <= 1'b1;
            case (state_reg)
                ST_IDLE: begin
                    if (exec_start && !cache_refuse) begin
                        last_cond_reg <= do_exec;
                        cycles_reg    <= base_cycles;
                        // counter side effects of a test
                        if (is_cond || is_event) begin
                            if (condition_code == `CC_COUNTER_ZERO_NONNEG_TEST || condition_code == `CC_C0LT)
                                loop_counter_zero_reg <= loop_counter_zero_reg + 16'h0001;
                            if (condition_code == `CC_HEADS || condition_code == `CC_TAILS)
                                prng_reg <= {prng_reg[8:0], prng_reg[9] ^ prng_reg[6]};
                        end
                        if (is_event && !is_ctrl) begin
                            loop_counter_one_reg <= loop_counter_one_reg + 16'h0001;
                            if (cond_true)
                                counter_snapshot_reg <= loop_counter_one_reg + 16'h0001;
                        end else if ((is_cond || is_event) &&
                                     (condition_code == `CC_C1GE ||
                                      condition_code == `CC_COUNTER_ONE_NEGATIVE_TEST)) begin
                            loop_counter_one_reg <= loop_counter_one_reg + 16'h0001;
                        end
                        if (!is_ctrl) begin
                            if (do_exec) begin
                                if (dest_sel)
                                    acc1_reg <= sf_result;
                                else
                                    acc0_reg <= sf_result;
                            end
                            pc_reg <= pc_plus1;
                            pc_o   <= pc_plus1;
                        end else if (do_exec) begin
                            pc_reg <= ctrl_target;
                            pc_o   <= ctrl_target;
                            branch_taken_o <= 1'b1;
                            if (opcode == `CT_CALL_ABS || opcode == `CT_CALL_PTR)
                                subroutine_return_reg <= next_seq;
                            if (opcode == `CT_ICALL)
                                interrupt_return_reg <= next_seq;
                        end else begin
                            pc_reg <= next_seq;
                            pc_o   <= next_seq;
                        end
                        // the result lands now; busy covers the remaining cycles
                        if (total_cycles > 5'h01) begin
                            wait_count_reg <= total_cycles - 5'h01;
                            state_reg      <= ST_WAIT;
                            busy_o         <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (wait_count_reg == 5'h01) begin
                        state_reg <= ST_IDLE;
                        busy_o    <= 1'b0;
                    end
                    wait_count_reg <= wait_count_reg - 5'h01;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // read mux: word-aligned addresses, unmapped reads return zero
    reg [31:0] rd_data;
    always @* begin
        if (adr_i == `OFF_INSTR)
            rd_data = {16'h0000, instr_reg};
        else if (adr_i == `OFF_SRC)
            rd_data = {pc_reg, table_pointer_reg};
        else if (adr_i == `OFF_ACC0_LO)
            rd_data = acc0_reg[31:0];
        else if (adr_i == `OFF_ACC0_HI)
            rd_data = {28'h0000000, acc0_reg[35:32]};
        else if (adr_i == `OFF_ACC1_LO)
            rd_data = acc1_reg[31:0];
        else if (adr_i == `OFF_ACC1_HI)
            rd_data = {28'h0000000, acc1_reg[35:32]};
        else if (adr_i == `OFF_COUNTERS)
            rd_data = {loop_counter_one_reg, loop_counter_zero_reg};
        else if (adr_i == `OFF_SNAPSHOT)
            rd_data = {16'h0000, counter_snapshot_reg};
        else if (adr_i == `OFF_PC)
            rd_data = {16'h0000, pc_reg};
        else if (adr_i == `OFF_STATUS)
            rd_data = {16'h0000, prng_reg, cycles_reg, last_cond_reg, busy_o,
                       cache_err_reg};
        else if (adr_i == `OFF_FLAGS)
            rd_data = {28'h0000000, flags_reg};
        else if (adr_i == `OFF_RETREGS)
            rd_data = {interrupt_return_reg, subroutine_return_reg};
        else if (adr_i == `OFF_CONFIG)
            rd_data = {28'h0000000, wait_states_reg};
        else
            rd_data = 32'h00000000;
    end

    // single-cycle ack; ack drops the cycle after it is given
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_data : 32'h00000000;
        end
    end

endmodule

// ===== sim/dsp_exec_asserts.sv
// port checker for the execution block
`timescale 1ns/10ps
module dsp_exec_asserts (
    // watched ports
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_i,
    input wire        ack_o,
    input wire        cache_active_i,
    input wire        busy_o,
    input wire        branch_taken_o,
    input wire [15:0] pc_o
);
    reg  [15:0] instr_reg;
    wire        req = cyc_i && stb_i && we_i && !ack_o && !busy_o;
    wire        go  = req && adr_i == 8'h08;
    wire        ctl = go && instr_reg[15:14] == 2'h1 && !cache_active_i && !pc_o[15];
    wire        jmp = ctl && instr_reg[9:5] == 5'h00;
    // shadow of the word a start runs; writes while busy are refused
    always @(posedge clk_i) begin
        if (req && adr_i == 8'h00) begin
            instr_reg <= dat_i[15:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_special_single: assert property (go && instr_reg[15:14] == 2'h0 && !pc_o[15]
        |=> !busy_o && pc_o == $past(pc_o) + 16'h1) else $error("special length");
    a_goto_two: assert property (jmp && !instr_reg[13]
        |=> busy_o && branch_taken_o ##1 !busy_o) else $error("goto length");
    a_icall_three: assert property (ctl && instr_reg[9:5] == 5'h04
        |=> busy_o [*2] ##1 !busy_o) else $error("icall length");
    a_cond_three: assert property (jmp && instr_reg[13]
        |=> busy_o [*2] ##1 !busy_o) else $error("conditional length");
    a_skip_false: assert property (jmp && instr_reg[13] && instr_reg[4:0] == 5'h11
        |=> !branch_taken_o && pc_o == $past(pc_o) + 16'h2) else $error("skip");
    a_page_join: assert property (jmp && !instr_reg[13] && pc_o[11:1] != 11'h7ff
        |=> pc_o == (($past(pc_o) & 16'hf000) | ($past(instr_reg) & 16'h0fff)))
        else $error("page join");
    a_cache_block: assert property (go && instr_reg[15:14] == 2'h1 && cache_active_i
        |=> !branch_taken_o && $stable(pc_o)) else $error("cache refusal");
    c_cond: cover property (jmp && instr_reg[13]);
    c_icall: cover property (ctl && instr_reg[9:5] == 5'h04);
    c_cache: cover property (go && cache_active_i);
endmodule
bind dsp_exec dsp_exec_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .cache_active_i(cache_active_i),
    .busy_o(busy_o), .branch_taken_o(branch_taken_o), .pc_o(pc_o));

// ===== sim/dsp_exec_tb_top.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
module dsp_exec_tb_top;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, fwe = 1'b0, cache = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [31:0] wd = 32'h0, my = 32'h0, mp = 32'h0, rd;
    reg  [3:0]  fl = 4'h0, bit_io_unit = 4'h0;
    reg  [2:0]  misc = 3'h0;
    reg  [1:0]  bit_manipulation_unit = 2'h0;
    reg  [35:0] a, e;
    reg  [28:0] v;
    wire [31:0] dat_o;
    wire        ack_o, busy_o, bt;
    wire [15:0] pc_o;
    integer     num_errors = 0, cmp_count = 0, i, s, nb = 0, nbt = 0;
    always #2 clk_i = ~clk_i;
    // busy cycles and branch pulses seen since the last start
    always @(posedge clk_i) begin
        if (busy_o === 1'b1) nb = nb + 1;
        if (bt === 1'b1) nbt = nbt + 1;
    end
    dsp_exec dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
        .sel_i(4'hf), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o), .mult_input_i(my),
        .product_i(mp), .result_flags_i(fl), .result_flags_we_i(fwe), .bmu_flags_i(bit_manipulation_unit),
        .bio_compare_i(bit_io_unit), .pll_lock_i(misc[2]), .njint_i(misc[1]), .npint_i(misc[0]),
        .cache_active_i(cache), .busy_o(busy_o), .branch_taken_o(bt), .pc_o(pc_o));
    task check(input [35:0] seen, input [35:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("Error %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wb(input w, input [7:0] ad, input [31:0] d);
        begin
            cyc <= 1'b1;
            we <= w;
            adr <= ad;
            wd <= d;
            @(posedge clk_i);
            while (ack_o !== 1'b1) @(posedge clk_i);
            rd = dat_o;
            cyc <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // load a word, start it, wait out busy, then fetch status
    task run(input [15:0] ins);
        begin
            wb(1'b1, 8'h00, {16'h0, ins});
            nb = 0;
            nbt = 0;
            wb(1'b1, 8'h08, 32'h0);
            while (busy_o !== 1'b0) @(posedge clk_i);
            wb(1'b0, 8'h28, 32'h0);
        end
    endtask
    task tally_and_finish;
        begin
            $display("errors %0d compares %0d", num_errors, cmp_count);
            if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #40000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        s = $urandom(71);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // each special function on a random acc0, result into acc1
        for (i = 0; i < 16; i = i + 1) begin
            s = $urandom;
            a = {s[3:0], $urandom};
            my <= $urandom;
            mp <= $urandom;
            wb(1'b1, 8'h0c, a[31:0]);
            wb(1'b1, 8'h10, {28'h0, a[35:32]});
            run({6'h02, i[4:0], 5'h00});
            check(rd[5:3], 36'h1);
            s = (i % 4 == 0) ? 1 : 2 << (i % 4);
            case (i)
                0, 1, 2, 3: e = $signed(a) >>> s;
                4: e = a;
                5: e = -a;
                6: e = ~a;
                7: e = (a + 36'h8000) & 36'hf_ffff_0000;
                8: e = {a[35:16] + 20'h1, 16'h0};
                9: e = a + 36'h1;
                10: e = {{4{my[31]}}, my};
                11: e = {{4{mp[31]}}, mp};
                default: e = a << s;
            endcase
            if (i > 11) e[35:32] = {4{e[31]}};
            wb(1'b0, 8'h14, 32'h0);
            a[31:0] = rd;
            wb(1'b0, 8'h18, 32'h0);
            a[35:32] = rd[3:0];
            check(a, e);
        end
        // event prefix taken and not taken, then a counter-one test
        wb(1'b1, 8'h1c, 32'h0005_0003);
        run(16'h3890);
        run(16'h3891);
        run(16'h208c);
        check(rd[2], 36'h1);
        wb(1'b0, 8'h1c, 32'h0);
        check(rd, 36'h0008_0003);
        wb(1'b0, 8'h20, 32'h0);
        check(rd[15:0], 36'h6);
        // stored flags must win over the live input that follows; counters stay
        // positive here and the random bit starts from its reset value
        for (i = 0; i < 29; i = i + 1) begin
            s = $urandom;
            {misc, bit_manipulation_unit, bit_io_unit, fl} <= s[12:0];
            fwe <= 1'b1;
            @(posedge clk_i);
            fwe <= 1'b0;
            fl <= ~s[3:0];
            run(16'h2080 | i[15:0]);
            v = {s[12:10], ~s[9], s[9], ~s[8], s[8], s[7:4], 8'h75, ~s[3], s[3], ~s[2], s[2],
                s[0] | s[1], ~(s[0] | s[1]), ~s[1], s[1], ~s[0], s[0]};
            check(rd[2], v[i]);
        end
        check(rd[15:6], 36'h4);
        // page-relative jumps, a skip, the debug call, a cache refusal, external wait
        wb(1'b1, 8'h04, 32'h1234_0100);
        run(16'h4c1f);
        check(pc_o, 36'h1c1f);
        check(nbt, 36'h1);
        check(rd[5:3], 36'h2);
        run(16'h6011);
        check(pc_o, 36'h1c21);
        check(nbt, 36'h0);
        check(rd[5:3], 36'h3);
        run(16'h4080);
        check(rd[5:3], 36'h3);
        run(16'h60d1);
        check(pc_o, 36'h1c22);
        check(rd[5:3], 36'h2);
        wb(1'b1, 8'h04, 32'h2ffe_0100);
        run(16'h4c1f);
        check(pc_o, 36'h3c1f);
        cache <= 1'b1;
        run(16'h4c1f);
        check(rd[0], 36'h1);
        check(pc_o, 36'h3c1f);
        cache <= 1'b0;
        wb(1'b1, 8'h34, 32'h3);
        wb(1'b1, 8'h04, 32'h8000_0100);
        run(16'h0880);
        check(rd[5:3], 36'h1);
        check(nb + 1, 36'h4);
        wb(1'b0, 8'hfc, 32'h0);
        check(rd, 36'h0);
        tally_and_finish;
    end
endmodule
